// ---- rtl/sdwl_pkg.sv ----
package sdwl_pkg;
   localparam int WORD_BITS = 16;
   localparam int CNT_BITS = 5;
   localparam int SEG_BITS = 4;
   localparam int LADDER_BITS = 12;
   localparam int SEG_COUNT = 15;
   localparam logic [15:0] ZERO_CODE = 16'h0000;
   localparam logic [15:0] MID_CODE = 16'h8000;
   localparam logic [4:0] WORD_COUNT = 5'h10;
   localparam logic [1:0] RST_WAIT = 2'h3;
   localparam int SYS_CLK_MHZ = 10;
   localparam int LINK_MAX_MBPS = 50;
   localparam int DIV_HALF_DEFAULT = 1;
   localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
endpackage

// ---- rtl/sdwl_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface sdwl_link_if;
   logic serialClk;
   logic chipSelectN;
   logic serialData;
   logic latchLoadN;
   modport master (output serialClk, output chipSelectN, output serialData, output latchLoadN);
   modport device (input serialClk, input chipSelectN, input serialData, input latchLoadN);
endinterface
`default_nettype wire

// ---- rtl/sdwl_therm_decode.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdwl_therm_decode
   import sdwl_pkg::*;
(
   input wire logic [SEG_BITS-1:0] code,
   output logic [SEG_COUNT-1:0] therm
);
   // segment k on when code exceeds k
   genvar k;
   generate
      for (k = 0; k < SEG_COUNT; k++) begin : g_seg
         assign therm[k] = (code > SEG_BITS'(k));
      end
   endgenerate
endmodule
`default_nettype wire

// ---- rtl/sdwl_device.sv ----
`timescale 1ns/1ns
`default_nettype none
// How it works
// - one 16-bit word per frame, 16-bit registers
// - write-only port, no data output
// - master keeps link at most 50 Mbit/s
// - master alone drives clock and starts frames
// - select high: data not shifted, clock still steps select and load synchronisers
// - master changes data on falling clock edge
// - rising edge with select low shifts MSB first
// - select rising copies shifter to input register
// - master sends 16 clocks, then raises select
// - extra clocks keep only last 16 bits
// - short frame invalid, master resends word (sdwl_master never resends; word still copied to input register)
// - latch-load low copies input register to latch
// - master holds latch-load high during frame when useLoadPulse is set, low otherwise
// - latch-load tied low updates latch at once
// - reset select sets input register and latch
// - select low resets latch to zero
// - select high resets latch to mid-scale
// - top four bits thermometer, twelve to ladder
// - output follows latch, unsigned 65536 steps
module sdwl_device
   import sdwl_pkg::*;
(
   sdwl_link_if.device link,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic reset_value_select,
   output logic [SEG_COUNT-1:0] segment_switches,
   output logic [LADDER_BITS-1:0] ladder_switches,
   output logic [WORD_BITS-1:0] latchCode,
   output logic wordValid
);
   typedef struct packed {
      logic [WORD_BITS-1:0] shifter;
      logic [CNT_BITS-1:0] bitCount;
      logic [WORD_BITS-1:0] inputReg;
      logic [WORD_BITS-1:0] latch;
      logic [SEG_COUNT-1:0] seg;
      logic [LADDER_BITS-1:0] ladder;
      logic selPrev;
      logic loadPrev;
      logic valid;
      logic [1:0] resetWait;
      logic [1:0] selSync;
      logic [1:0] loadSync;
      logic [1:0] rstvSync;
   } sdwl_dev_state_t;

   sdwl_dev_state_t cur;
   sdwl_dev_state_t next_cur;
   logic [SEG_COUNT-1:0] thermNow;
   logic [WORD_BITS-1:0] resetCode;

   // reset code from synchronised select level
   assign resetCode = cur.rstvSync[1] ? MID_CODE : ZERO_CODE;

   sdwl_therm_decode u_therm (
      .code(next_cur.latch[WORD_BITS-1 -: SEG_BITS]),
      .therm(thermNow)
   );

   always_comb begin
      next_cur = cur;
      if (clkEn) begin
         next_cur.selSync = {cur.selSync[0], link.chipSelectN};
         next_cur.loadSync = {cur.loadSync[0], link.latchLoadN};
         next_cur.rstvSync = {cur.rstvSync[0], reset_value_select};
         next_cur.selPrev = cur.selSync[1];
         next_cur.loadPrev = cur.loadSync[1];
         // repeat until reset_value_select synchroniser is filled
         if (cur.resetWait != '0) begin
            next_cur.inputReg = resetCode;
            next_cur.latch = resetCode;
            next_cur.resetWait = cur.resetWait - 2'h1;
         end
         if (!link.chipSelectN) begin
            next_cur.shifter = {cur.shifter[WORD_BITS-2:0], link.serialData};
            if (cur.bitCount != WORD_COUNT) begin
               next_cur.bitCount = cur.bitCount + CNT_ONE;
            end
         end
         if (cur.selSync[1] && !cur.selPrev) begin
            next_cur.inputReg = cur.shifter;
            next_cur.valid = (cur.bitCount == WORD_COUNT);
            next_cur.bitCount = CNT_ZERO;
            if (!cur.loadSync[1]) begin
               next_cur.latch = cur.shifter;
            end
         end else if (!cur.loadSync[1] && cur.loadPrev && cur.selSync[1]) begin
            next_cur.latch = cur.inputReg;
         end
         next_cur.seg = thermNow;
         next_cur.ladder = next_cur.latch[LADDER_BITS-1:0];
      end
   end

   // link clock domain; no data ever driven back
   always_ff @(posedge link.serialClk or negedge resetn) begin
      if (!resetn) begin
         cur <= '0;
         cur.resetWait <= RST_WAIT;
         cur.selSync <= 2'h3;
         cur.loadSync <= 2'h3;
         cur.selPrev <= 1'b1;
         cur.loadPrev <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign segment_switches = cur.seg;
   assign ladder_switches = cur.ladder;
   assign latchCode = cur.latch;
   assign wordValid = cur.valid;
endmodule
`default_nettype wire

// ---- rtl/sdwl_master.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdwl_master
   import sdwl_pkg::*;
#(
   parameter int DIV_HALF = DIV_HALF_DEFAULT,
   parameter int TAIL_CLOCKS = 4
)(
   sdwl_link_if.master link,
   input wire logic clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic sendReq,
   input wire logic [WORD_BITS-1:0] sendWord,
   input wire logic useLoadPulse,
   output logic busy,
   output logic done
);
   typedef enum logic [2:0] {IDLE, SHIFT, TAIL, PULSE, GAP} sdwl_mst_phase_t;
   typedef struct packed {
      sdwl_mst_phase_t phase;
      logic [WORD_BITS-1:0] word;
      logic [CNT_BITS-1:0] bits;
      logic [7:0] div;
      logic [7:0] tail;
      logic sclk;
      logic csn;
      logic sdo;
      logic ldn;
      logic pulseMode;
      logic busy;
      logic done;
   } sdwl_mst_state_t;

   sdwl_mst_state_t cur;
   sdwl_mst_state_t next_cur;
   logic tick;

   assign tick = (cur.div == 8'(DIV_HALF - 1));

   always_comb begin
      next_cur = cur;
      if (clkEn) begin
         next_cur.done = 1'b0;
         next_cur.div = tick ? 8'h00 : cur.div + 8'h01;
         unique case (cur.phase)
            IDLE: begin
               next_cur.div = 8'h00;
               if (sendReq) begin
                  next_cur.word = sendWord;
                  next_cur.pulseMode = useLoadPulse;
                  next_cur.ldn = useLoadPulse;
                  next_cur.csn = 1'b0;
                  next_cur.sdo = sendWord[WORD_BITS-1];
                  next_cur.bits = CNT_ZERO;
                  next_cur.busy = 1'b1;
                  next_cur.phase = SHIFT;
               end
            end
            SHIFT: if (tick) begin
               next_cur.sclk = ~cur.sclk;
               if (cur.sclk) begin
                  next_cur.word = {cur.word[WORD_BITS-2:0], 1'b0};
                  next_cur.sdo = cur.word[WORD_BITS-2];
                  if (cur.bits == WORD_COUNT - CNT_ONE) begin
                     next_cur.csn = 1'b1;
                     next_cur.tail = 8'h00;
                     next_cur.phase = TAIL;
                  end
                  next_cur.bits = cur.bits + CNT_ONE;
               end
            end
            TAIL: if (tick) begin
               next_cur.sclk = ~cur.sclk;
               if (cur.tail == 8'(TAIL_CLOCKS)) begin
                  next_cur.sclk = 1'b0;
                  next_cur.ldn = 1'b0;
                  next_cur.tail = 8'h00;
                  next_cur.phase = cur.pulseMode ? PULSE : GAP;
               end else begin
                  next_cur.tail = cur.tail + 8'h01;
               end
            end
            PULSE: if (tick) begin
               next_cur.sclk = ~cur.sclk;
               if (cur.tail == 8'(TAIL_CLOCKS)) begin
                  next_cur.sclk = 1'b0;
                  next_cur.ldn = 1'b1;
                  next_cur.tail = 8'h00;
                  next_cur.phase = GAP;
               end else begin
                  next_cur.tail = cur.tail + 8'h01;
               end
            end
            GAP: if (tick) begin
               next_cur.sclk = ~cur.sclk;
               if (cur.tail == 8'(TAIL_CLOCKS)) begin
                  next_cur.sclk = 1'b0;
                  next_cur.ldn = cur.pulseMode;
                  next_cur.busy = 1'b0;
                  next_cur.done = 1'b1;
                  next_cur.phase = IDLE;
               end else begin
                  next_cur.tail = cur.tail + 8'h01;
               end
            end
         endcase
      end
   end

   // clock runs during tail so device crosses select edges; via divider
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur <= '0;
         cur.phase <= IDLE;
         cur.csn <= 1'b1;
         cur.ldn <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign link.serialClk = cur.sclk;
   assign link.chipSelectN = cur.csn;
   assign link.serialData = cur.sdo;
   assign link.latchLoadN = cur.ldn;
   assign busy = cur.busy;
   assign done = cur.done;
endmodule
`default_nettype wire

// ---- tb/sdwl_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdwl_sva
   import sdwl_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic serialClk,
   input wire logic chipSelectN,
   input wire logic serialData,
   input wire logic latchLoadN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [CNT_BITS-1:0] riseCnt;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         riseCnt <= CNT_ZERO;
      end else if (chipSelectN) begin
         riseCnt <= CNT_ZERO;
      end else if ($rose(serialClk)) begin
         riseCnt <= riseCnt + CNT_ONE;
      end
   end
   sequence s_frameEnd; ##[16:64] $rose(chipSelectN); endsequence
   sequence s_loadLow; !latchLoadN [*5]; endsequence
   property p_sixteen; $rose(chipSelectN) |-> riseCnt == WORD_COUNT; endproperty
   a_sixteen: assert property (p_sixteen) else $error("bad clock count");
   property p_frameLen; $fell(chipSelectN) |-> s_frameEnd; endproperty
   a_frameLen: assert property (p_frameLen) else $error("frame too long");
   property p_csAfterFall; $rose(chipSelectN) |-> !serialClk; endproperty
   a_csAfterFall: assert property (p_csAfterFall) else $error("select rose with clock high");
   property p_startLow; $fell(chipSelectN) |-> !serialClk; endproperty
   a_startLow: assert property (p_startLow) else $error("frame began with clock high");
   property p_dataOnFall;
      !chipSelectN && !$past(chipSelectN) && $changed(serialData) |-> $fell(serialClk);
   endproperty
   a_dataOnFall: assert property (p_dataOnFall) else $error("data moved off falling edge");
   property p_ldHigh;
      !chipSelectN && !$past(chipSelectN) && $past(latchLoadN) |-> latchLoadN;
   endproperty
   a_ldHigh: assert property (p_ldHigh) else $error("load dropped inside frame");
   property p_loadPulse; chipSelectN && $fell(latchLoadN) |-> s_loadLow; endproperty
   a_loadPulse: assert property (p_loadPulse) else $error("load pulse too short");
   property p_gap; $rose(chipSelectN) |=> chipSelectN [*2]; endproperty
   a_gap: assert property (p_gap) else $error("select gap too short");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
   import sdwl_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, sendReq = 1'b0, useLoadPulse = 1'b1, rvs = 1'b0;
   logic [WORD_BITS-1:0] sendWord = 16'h0000;
   logic busy, done, ok, ok2;
   logic [SEG_COUNT-1:0] seg;
   logic [LADDER_BITS-1:0] lad;
   logic [WORD_BITS-1:0] code, code2;
   int n_mismatch = 0, checks_done = 0;
   sdwl_link_if l1();
   sdwl_link_if l2();
   always #50 clk = ~clk;
   sdwl_master sdwl_master_i(.link(l1), .clk(clk), .resetn(resetn), .clkEn(1'b1),
      .sendReq(sendReq), .sendWord(sendWord), .useLoadPulse(useLoadPulse), .busy(busy),
      .done(done));
   sdwl_device sdwl_device_i(.link(l1), .resetn(resetn), .clkEn(1'b1),
      .reset_value_select(rvs), .segment_switches(seg), .ladder_switches(lad),
      .latchCode(code), .wordValid(ok));
   sdwl_device sdwl_device_i2(.link(l2), .resetn(resetn), .clkEn(1'b1),
      .reset_value_select(rvs), .segment_switches(), .ladder_switches(),
      .latchCode(code2), .wordValid(ok2));
   sdwl_sva sdwl_sva_i(.clk(clk), .resetn(resetn), .serialClk(l1.serialClk),
      .chipSelectN(l1.chipSelectN), .serialData(l1.serialData), .latchLoadN(l1.latchLoadN));
   initial begin
      l2.serialClk = 1'b0;
      l2.chipSelectN = 1'b1;
      l2.serialData = 1'b0;
      l2.latchLoadN = 1'b1;
   end
   function automatic logic [14:0] th(input logic [3:0] c);
      th = (15'h0001 << c) - 15'h0001;
   endfunction
   task automatic send(input logic [15:0] w, input logic p);
      int k;
      k = 0;
      @(posedge clk);
      #1 sendReq = 1'b1;
      sendWord = w;
      useLoadPulse = p;
      @(posedge clk);
      #1 sendReq = 1'b0;
      `CHK(busy, 1'b1)
      do begin @(posedge clk); #1 k++; end while (done !== 1'b1 && k < 300);
      `CHK(done, 1'b1)
      `CHK(busy, 1'b0)
      repeat (10) @(posedge clk);
      #1 `CHK(code, w)
      `CHK(lad, w[11:0])
      `CHK(seg, th(w[15:12]))
      `CHK(ok, 1'b1)
   endtask
   task automatic frame(input logic [31:0] b, input int n, input logic cs);
      int i;
      l2.chipSelectN = cs;
      for (i = n - 1; i >= 0; i--) begin
         l2.serialData = b[i];
         #3 l2.serialClk = 1'b1;
         #3 l2.serialClk = 1'b0;
      end
      #3 l2.chipSelectN = 1'b1;
      l2.serialData = ~l2.serialData;
      for (i = 0; i < 12; i++) begin
         l2.latchLoadN = !(i > 1 && i < 6);
         #3 l2.serialClk = 1'b1;
         #3 l2.serialClk = 1'b0;
      end
   endtask
   task automatic t_zero;
      frame(32'h0000_0000, 4, 1'b1);
      `CHK(code2, ZERO_CODE)
      `CHK(code, ZERO_CODE)
      $display("zero reset test end");
   endtask
   task automatic t_pulse;
      send(16'hA5C3, 1'b1);
      send(16'h0001, 1'b1);
      $display("pulse load test end");
   endtask
   task automatic t_tied;
      send(16'hFFFF, 1'b0);
      send(16'h7E18, 1'b0);
      $display("tied load test end");
   endtask
   task automatic t_frames;
      frame(32'h0003_BEEF, 20, 1'b0);
      `CHK(code2, 16'hBEEF)
      frame(32'h0000_1234, 16, 1'b1);
      `CHK(code2, 16'hBEEF)
      frame(32'h0000_00A5, 8, 1'b0);
      `CHK(ok2, 1'b0)
      $display("frame length test end");
   endtask
   task automatic t_mid;
      rvs = 1'b1;
      frame(32'h0000_0000, 4, 1'b1);
      @(posedge clk);
      #1 resetn = 1'b0;
      repeat (3) @(posedge clk);
      #1 resetn = 1'b1;
      frame(32'h0000_0000, 4, 1'b1);
      `CHK(code2, MID_CODE)
      `CHK(ok2, 1'b0)
      $display("mid reset test end");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1 resetn = 1'b1;
      t_zero();
      t_pulse();
      t_tied();
      t_frames();
      t_mid();
      complete_run();
   end
   initial begin
      #400000;
      n_mismatch++;
      complete_run();
   end
endmodule
`default_nettype wire
